// *** hw/ssc_consts.svh ***
// constants for the serial clock management and transmit path
// Function
// - twelve-bit divide value, division up to 8190
// - divide value zero keeps divider idle
// - each divided level lasts divide-value cycles
// - divided clock feeds transmitter and receiver
// - transmit clock from pin, receiver, divider
// - transmit invert independent of receive invert
// - transmit pin driven continuously or during transfer
// - inversion never reaches the clock pins
// - receive clock from pin, transmitter, divider
// - receive invert independent of transmit invert
// - receive pin driven continuously or during transfer
// - each frame begins on configured start event
// - holding word moves to shifter, shifted out
// - all-empty set when holding and shifter empty
// - holding-free set when word moves to shifter
// - directions independent, may share clock or start
// - interrupt while unmasked event pending, status shows cause
// - continuous mode starts on holding write
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// divider field
`define SSC_DIV_W 12
`define SSC_DIV_RESET 12'h000
`define SSC_DIV_ONE 12'h001

// word and frame sizing
`define SSC_WORD_W 32
`define SSC_BITIDX_W 5
`define SSC_WORDNB_W 4

// pins passed through the synchroniser: tk, rk, tf
`define SSC_SYNC_W 3
`define SSC_SYNC_TK 0
`define SSC_SYNC_RK 1
`define SSC_SYNC_TF 2

// status vector layout
`define SSC_FLAG_W 2
`define SSC_FLAG_FREE 0
`define SSC_FLAG_EMPTY 1
`define SSC_FLAG_RESET 2'h3

`endif

// *** hw/ssc_pkg.sv ***
// types shared by the serial clock and transmit modules
package ssc_pkg;

	// clock source choice: own pin, other direction, divider
	typedef enum logic [1:0] {CK_SRC_PIN, CK_SRC_OTHER, CK_SRC_DIV} clk_src_t;

	// clock pin use: input only, always driven, driven while busy
	typedef enum logic [1:0] {CKO_INPUT, CKO_CONTINUOUS, CKO_TRANSFER} clk_out_t;

	// transmit start event
	typedef enum logic [2:0] {
		START_CONT,
		START_RX,
		START_TF_LOW,
		START_TF_HIGH,
		START_TF_FALL,
		START_TF_RISE
	} start_t;

	// transmitter sequencing
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

// *** hw/div_if.sv ***
// link between the top and the master clock divider
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
interface div_if;
	logic [`SSC_DIV_W-1:0] div; // divide value
	logic div_clk; // divided clock level
	logic active; // divider running
	modport ctrl (output div, input div_clk, input active);
	modport gen (input div, output div_clk, output active);
endinterface
`default_nettype wire

// *** hw/ssc_sync2.sv ***
// two-flop synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_sync2 (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// pins in, synchronised levels out
	input wire logic [`SSC_SYNC_W-1:0] i_pin,
	output logic [`SSC_SYNC_W-1:0] o_level
);
	genvar g;
	generate
		for (g = 0; g < `SSC_SYNC_W; g++)
		begin : g_bit
			logic meta_q; // first stage, read only by second
			logic meta_d;
			logic lvl_q; // second stage
			logic lvl_d;
			// next values
			always_comb
			begin
				meta_d = i_pin[g];
				lvl_d = meta_q;
			end
			// registers
			always_ff @(posedge i_sys_clk)
			begin
				if (i_rst)
				begin
					meta_q <= 1'b0;
					lvl_q <= 1'b0;
				end
				else
				begin
					meta_q <= meta_d;
					lvl_q <= lvl_d;
				end
			end
			assign o_level[g] = lvl_q;
		end
	endgenerate
endmodule
`default_nettype wire

// *** hw/ssc_clk_div.sv ***
// master clock divider with half-and-half duty
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_clk_div (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// divide value in, divided clock out
	div_if.gen bus
);
	logic [`SSC_DIV_W-1:0] cnt_q; // cycles spent in current level
	logic [`SSC_DIV_W-1:0] cnt_d;
	logic clk_q; // divided level
	logic clk_d;
	logic act_q; // divider running
	logic act_d;

	// next values; compare with >= so a shrunk value mid-level still wraps
	always_comb
	begin
		cnt_d = cnt_q;
		clk_d = clk_q;
		act_d = 1'b1;
		if (bus.div == `SSC_DIV_RESET)
		begin
			// idle: no divided clock at all
			cnt_d = `SSC_DIV_RESET;
			clk_d = 1'b0;
			act_d = 1'b0;
		end
		else if (cnt_q >= bus.div - `SSC_DIV_ONE)
		begin
			// level has lasted divide-value cycles: toggle
			cnt_d = `SSC_DIV_RESET;
			clk_d = ~clk_q;
		end
		else
		begin
			cnt_d = cnt_q + `SSC_DIV_ONE;
		end
	end

	// registers
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			cnt_q <= `SSC_DIV_RESET;
			clk_q <= 1'b0;
			act_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
			act_q <= act_d;
		end
	end

	assign bus.div_clk = clk_q;
	assign bus.active = act_q;
endmodule
`default_nettype wire

// *** hw/ssc_clk_tx.sv ***
// clock selection, clock pins and transmit holding/shift path
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_clk_tx
	import ssc_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// divider setting
	input wire logic [`SSC_DIV_W-1:0] i_div_value,
	// transmit clock mode
	input wire clk_src_t i_tx_clk_src,
	input wire logic i_tx_clk_inv,
	input wire clk_out_t i_tx_clk_out,
	input wire start_t i_tx_start_mode,
	// receive clock mode
	input wire clk_src_t i_rx_clk_src,
	input wire logic i_rx_clk_inv,
	input wire clk_out_t i_rx_clk_out,
	// transmit frame format
	input wire logic [`SSC_BITIDX_W-1:0] i_tx_datlen,
	input wire logic [`SSC_WORDNB_W-1:0] i_tx_datnb,
	input wire logic i_tx_msbf,
	input wire logic i_tx_datdef,
	// holding register write
	input wire logic i_thr_wr,
	input wire logic [`SSC_WORD_W-1:0] i_thr_data,
	// receiver side, same clock
	input wire logic i_rx_start,
	input wire logic i_rx_busy,
	// interrupt mask
	input wire logic [`SSC_FLAG_W-1:0] i_irq_mask,
	// serial pins
	input wire logic i_tk,
	output logic o_tk,
	output logic o_tk_oe,
	input wire logic i_rk,
	output logic o_rk,
	output logic o_rk_oe,
	input wire logic i_tf,
	output logic o_td,
	// internal clocks for the data paths
	output logic o_tx_int_clk,
	output logic o_rx_int_clk,
	output logic o_div_active,
	// status and events
	output logic o_tx_start,
	output logic o_tx_holding_free,
	output logic o_tx_all_empty,
	output logic [`SSC_FLAG_W-1:0] o_flag_status,
	output logic o_irq
);
	// synchronised pins
	logic [`SSC_SYNC_W-1:0] pin_s;
	logic tk_s; // tk level after two flops
	logic rk_s; // rk level after two flops
	logic tf_s; // tf level after two flops
	div_if div_bus ();

	ssc_sync2 u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_pin({i_tf, i_rk, i_tk}),
		.o_level(pin_s)
	);

	ssc_clk_div u_div (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.bus(div_bus.gen)
	);

	assign div_bus.div = i_div_value;
	assign tk_s = pin_s[`SSC_SYNC_TK];
	assign tf_s = pin_s[`SSC_SYNC_TF];
	assign rk_s = pin_s[`SSC_SYNC_RK];

	// clock selection group
	logic tx_base; // tx clock ignoring its other-direction choice
	logic rx_base; // rx clock ignoring its other-direction choice
	logic tx_clk; // selected transmit clock, pin polarity
	logic rx_clk; // selected receive clock, pin polarity
	logic tx_int_d;
	logic tx_int_q; // inverted-as-programmed transmit clock
	logic rx_int_d;
	logic rx_int_q;
	logic tk_d;
	logic tk_q;
	logic tk_oe_d;
	logic tk_oe_q;
	logic rk_d;
	logic rk_q;
	logic rk_oe_d;
	logic rk_oe_q;
	logic tx_busy; // shifter holds a word

	// clock muxing; the cross choice uses the other side's base clock so
	// that both pointing at each other cannot form a loop
	always_comb
	begin
		unique case (i_tx_clk_src)
			CK_SRC_PIN: tx_base = tk_s;
			CK_SRC_DIV: tx_base = div_bus.div_clk;
			default: tx_base = 1'b0; // cross or illegal code
		endcase
		unique case (i_rx_clk_src)
			CK_SRC_PIN: rx_base = rk_s;
			CK_SRC_DIV: rx_base = div_bus.div_clk;
			default: rx_base = 1'b0;
		endcase
		// transmit may run on the receive clock
		tx_clk = (i_tx_clk_src == CK_SRC_OTHER) ? rx_base : tx_base;
		// receive may run on the transmit clock
		rx_clk = (i_rx_clk_src == CK_SRC_OTHER) ? tx_base : rx_base;
		// inversion only on the internal copies
		tx_int_d = tx_clk ^ i_tx_clk_inv;
		rx_int_d = rx_clk ^ i_rx_clk_inv;
		// pins carry the uninverted clock
		tk_d = tx_clk;
		rk_d = rx_clk;
		// pin drive per output mode; pin source plus continuous is
		// left to software to avoid, it would drive its own input
		unique case (i_tx_clk_out)
			CKO_CONTINUOUS: tk_oe_d = 1'b1;
			CKO_TRANSFER: tk_oe_d = tx_busy;
			default: tk_oe_d = 1'b0;
		endcase
		unique case (i_rx_clk_out)
			CKO_CONTINUOUS: rk_oe_d = 1'b1;
			CKO_TRANSFER: rk_oe_d = i_rx_busy;
			default: rk_oe_d = 1'b0;
		endcase
	end

	// clock registers
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			tx_int_q <= 1'b0;
			rx_int_q <= 1'b0;
			tk_q <= 1'b0;
			tk_oe_q <= 1'b0;
			rk_q <= 1'b0;
			rk_oe_q <= 1'b0;
		end
		else
		begin
			tx_int_q <= tx_int_d;
			rx_int_q <= rx_int_d;
			tk_q <= tk_d;
			tk_oe_q <= tk_oe_d;
			rk_q <= rk_d;
			rk_oe_q <= rk_oe_d;
		end
	end

	// transmit path group
	tx_state_t state_q; // idle or shifting
	tx_state_t state_d;
	logic [`SSC_WORD_W-1:0] hold_q; // holding register
	logic [`SSC_WORD_W-1:0] hold_d;
	logic hold_full_q; // holding register has a word
	logic hold_full_d;
	logic [`SSC_WORD_W-1:0] shreg_q; // shift register
	logic [`SSC_WORD_W-1:0] shreg_d;
	logic [`SSC_BITIDX_W-1:0] bit_q; // bits sent of current word
	logic [`SSC_BITIDX_W-1:0] bit_d;
	logic [`SSC_WORDNB_W-1:0] words_q; // words still owed this frame
	logic [`SSC_WORDNB_W-1:0] words_d;
	logic td_d;
	logic td_q;
	logic tf_prev_q; // tf one cycle back, for edges
	logic tf_prev_d;
	logic pend_q; // start event latched until used
	logic pend_d;
	logic start_d;
	logic start_q;
	logic free_d;
	logic free_q;
	logic empty_d;
	logic empty_q;
	logic irq_d;
	logic irq_q;
	logic shift_edge; // internal clock falls: drive next bit
	logic evt; // edge-type start event this cycle
	logic start_ok; // start condition met at this edge
	logic load; // holding word moves to shifter
	logic cont; // continuous start mode
	logic [`SSC_BITIDX_W-1:0] pos; // bit index to drive

	assign tx_busy = (state_q == TX_SHIFT);

	// sequencing of holding register, shifter and flags
	always_comb
	begin
		state_d = state_q;
		hold_d = hold_q;
		hold_full_d = hold_full_q;
		shreg_d = shreg_q;
		bit_d = bit_q;
		words_d = words_q;
		td_d = td_q;
		tf_prev_d = tf_s;
		start_d = 1'b0;
		load = 1'b0;
		pos = '0;
		shift_edge = tx_int_q & ~tx_int_d;
		cont = (i_tx_start_mode == START_CONT);
		// edge events are latched so a short one between clock edges
		unique case (i_tx_start_mode)
			START_RX: evt = i_rx_start;
			START_TF_FALL: evt = tf_prev_q & ~tf_s;
			START_TF_RISE: evt = ~tf_prev_q & tf_s;
			default: evt = 1'b0;
		endcase
		// level events are judged at the shifting edge itself
		unique case (i_tx_start_mode)
			START_CONT: start_ok = hold_full_q;
			START_TF_LOW: start_ok = ~tf_s;
			START_TF_HIGH: start_ok = tf_s;
			default: start_ok = pend_q | evt;
		endcase
		if (shift_edge)
		begin
			unique case (state_q)
				TX_IDLE:
				begin
					// a frame waits for both its event and a word
					if (start_ok && hold_full_q)
					begin
						load = 1'b1;
						start_d = 1'b1;
						words_d = i_tx_datnb;
						state_d = TX_SHIFT;
					end
				end
				TX_SHIFT:
				begin
					if (bit_q != i_tx_datlen)
					begin
						// next bit of the current word
						bit_d = bit_q + 1'b1;
						pos = i_tx_msbf ? (i_tx_datlen - bit_d) : bit_d;
						td_d = shreg_q[pos];
					end
					else if (hold_full_q && (cont || words_q != '0))
					begin
						// word done, another follows in this frame
						load = 1'b1;
						if (!cont)
						begin
							words_d = words_q - 1'b1;
						end
					end
					else
					begin
						// frame over, line falls back to default level
						state_d = TX_IDLE;
						td_d = i_tx_datdef;
					end
				end
			endcase
		end
		else if (state_q == TX_IDLE)
		begin
			td_d = i_tx_datdef;
		end
		if (load)
		begin
			// first bit goes out on the same edge as the load
			shreg_d = hold_q;
			bit_d = '0;
			pos = i_tx_msbf ? i_tx_datlen : '0;
			td_d = hold_q[pos];
			hold_full_d = 1'b0;
		end
		// a write in the load cycle refills the holding register
		if (i_thr_wr)
		begin
			hold_d = i_thr_data;
			hold_full_d = 1'b1;
		end
		// event set wins over the clear made by a starting frame
		pend_d = evt | (pend_q & ~start_d);
		free_d = ~hold_full_d;
		empty_d = ~hold_full_d && (state_d == TX_IDLE);
		irq_d = |({empty_d, free_d} & i_irq_mask);
	end

	// transmit registers
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			state_q <= TX_IDLE;
			hold_q <= '0;
			hold_full_q <= 1'b0;
			shreg_q <= '0;
			bit_q <= '0;
			words_q <= '0;
			td_q <= 1'b0;
			tf_prev_q <= 1'b0;
			pend_q <= 1'b0;
			start_q <= 1'b0;
			free_q <= 1'b1;
			empty_q <= 1'b1;
			irq_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			hold_q <= hold_d;
			hold_full_q <= hold_full_d;
			shreg_q <= shreg_d;
			bit_q <= bit_d;
			words_q <= words_d;
			td_q <= td_d;
			tf_prev_q <= tf_prev_d;
			pend_q <= pend_d;
			start_q <= start_d;
			free_q <= free_d;
			empty_q <= empty_d;
			irq_q <= irq_d;
		end
	end

	// outputs, all straight from flops
	assign o_tk = tk_q;
	assign o_tk_oe = tk_oe_q;
	assign o_rk = rk_q;
	assign o_rk_oe = rk_oe_q;
	assign o_td = td_q;
	assign o_tx_int_clk = tx_int_q;
	assign o_rx_int_clk = rx_int_q;
	assign o_div_active = div_bus.active;
	assign o_tx_start = start_q;
	assign o_tx_holding_free = free_q;
	assign o_tx_all_empty = empty_q;
	assign o_flag_status = {empty_q, free_q};
	assign o_irq = irq_q;
endmodule
`default_nettype wire

// *** sim/ssc_clk_tx_props.sv ***
// concurrent checks on the clock and transmit block ports
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_clk_tx_props
	import ssc_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// watched inputs
	input wire logic [`SSC_DIV_W-1:0] i_div_value,
	input wire logic i_tx_clk_inv,
	input wire clk_out_t i_tx_clk_out,
	input wire logic i_thr_wr,
	input wire logic [`SSC_FLAG_W-1:0] i_irq_mask,
	// watched outputs
	input wire logic o_tk,
	input wire logic o_tk_oe,
	input wire logic o_tx_int_clk,
	input wire logic o_div_active,
	input wire logic o_tx_start,
	input wire logic o_tx_holding_free,
	input wire logic o_tx_all_empty,
	input wire logic [`SSC_FLAG_W-1:0] o_flag_status,
	input wire logic o_irq
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	// divide value held at zero over two edges
	sequence s_div_off;
		(i_div_value == 12'h000) [*2];
	endsequence
	// holding write, then two edges for the flags to settle
	sequence s_write;
		i_thr_wr ##2 1'b1;
	endsequence
	property p_div_idle;
		s_div_off |-> !o_div_active;
	endproperty
	a_div_idle: assert property (p_div_idle) else $error("divider active at zero");
	property p_div_run;
		(i_div_value != 12'h000) [*2] |-> o_div_active;
	endproperty
	a_div_run: assert property (p_div_run) else $error("divider idle at nonzero");
	property p_tk_cont;
		(i_tx_clk_out == CKO_CONTINUOUS) [*2] |-> o_tk_oe;
	endproperty
	a_tk_cont: assert property (p_tk_cont) else $error("clock pin not driven");
	property p_tk_in;
		(i_tx_clk_out == CKO_INPUT) [*2] |-> !o_tk_oe;
	endproperty
	a_tk_in: assert property (p_tk_in) else $error("clock pin driven as input");
	// pin copy must differ from the internal clock only by the invert setting
	property p_tk_plain;
		!$past(i_rst) && $stable(i_tx_clk_inv) |-> o_tk == (o_tx_int_clk ^ $past(i_tx_clk_inv));
	endproperty
	a_tk_plain: assert property (p_tk_plain) else $error("inversion on clock pin");
	property p_write_fills;
		s_write |-> !o_tx_all_empty;
	endproperty
	a_write_fills: assert property (p_write_fills) else $error("empty after write");
	property p_load_frees;
		o_tx_start && !$past(i_thr_wr) |-> o_tx_holding_free;
	endproperty
	a_load_frees: assert property (p_load_frees) else $error("holding not freed");
	property p_empty_free;
		o_tx_all_empty |-> o_tx_holding_free && o_flag_status == 2'h3;
	endproperty
	a_empty_free: assert property (p_empty_free) else $error("empty flag inconsistent");
	property p_irq;
		!$past(i_rst) && $stable(i_irq_mask) |-> o_irq == |(o_flag_status & i_irq_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
bind ssc_clk_tx ssc_clk_tx_props ssc_clk_tx_props_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_div_value(i_div_value), .i_tx_clk_inv(i_tx_clk_inv), .i_tx_clk_out(i_tx_clk_out),
	.i_thr_wr(i_thr_wr), .i_irq_mask(i_irq_mask), .o_tk(o_tk), .o_tk_oe(o_tk_oe),
	.o_tx_int_clk(o_tx_int_clk), .o_div_active(o_div_active), .o_tx_start(o_tx_start),
	.o_tx_holding_free(o_tx_holding_free), .o_tx_all_empty(o_tx_all_empty),
	.o_flag_status(o_flag_status), .o_irq(o_irq));
`default_nettype wire

// *** sim/codec_model.sv ***
// external serial device: supplies the transmit clock and frame sync
`timescale 1ns/10ps
`default_nettype none
module codec_model (
	// clock and frame enable
	input wire logic i_sys_clk,
	input wire logic i_en,
	// pins toward the block
	output logic o_tk,
	output logic o_tf
);
	logic [1:0] cnt_q; // cycles in the current level
	// a sixth of the system rate, still low outside frames
	always @(posedge i_sys_clk)
	begin
		if (!i_en)
		begin
			cnt_q <= 2'h0;
			o_tk <= 1'b0;
		end
		else if (cnt_q == 2'h2)
		begin
			cnt_q <= 2'h0;
			o_tk <= ~o_tk;
		end
		else
			cnt_q <= cnt_q + 2'h1;
	end
	// continuous start needs no frame sync
	assign o_tf = 1'b0;
endmodule
`default_nettype wire

// *** sim/ssc_clk_tx_test.sv ***
// self-checking bench for the clock selection and transmit path
`timescale 1ns/10ps
`default_nettype none
`include "ssc_consts.svh"
module ssc_clk_tx_test;
	import ssc_pkg::*;
	// stimulus, changed just after rising edges
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [11:0] div = 12'h000;
	clk_src_t tsrc = CK_SRC_DIV;
	clk_out_t tout = CKO_CONTINUOUS;
	clk_out_t rout = CKO_CONTINUOUS;
	logic tinv = 1'b0;
	logic rinv = 1'b1; // opposite sense to transmit
	logic [4:0] dlen = 5'h07;
	logic msbf = 1'b1;
	logic ddef = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [1:0] mask = 2'h2;
	logic pen = 1'b0; // partner clock runs during the second transfer only
	wire logic ptk, tf, o_tk, o_tk_oe, o_rk, o_rk_oe, td, tclk, rclk, dact, tstart, tfree, tempty, irq;
	wire logic [1:0] flags;
	wire logic tk = o_tk_oe ? o_tk : ptk; // block wins only while it drives
	wire logic rk = o_rk_oe ? o_rk : 1'b0; // pull-down, no external clock
	integer errors = 0;
	integer samples_checked = 0;
	integer seed = 79889;
	integer q[$]; // expected serial bits in order
	logic arm = 1'b0;
	logic tp = 1'b0;
	always #20 i_sys_clk = ~i_sys_clk;
	ssc_clk_tx ssc_clk_tx_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_div_value(div),
		.i_tx_clk_src(tsrc), .i_tx_clk_inv(tinv), .i_tx_clk_out(tout),
		.i_tx_start_mode(START_CONT), .i_rx_clk_src(CK_SRC_DIV), .i_rx_clk_inv(rinv),
		.i_rx_clk_out(rout), .i_tx_datlen(dlen), .i_tx_datnb(4'h0), .i_tx_msbf(msbf),
		.i_tx_datdef(ddef), .i_thr_wr(wr), .i_thr_data(wdata), .i_rx_start(1'b0),
		.i_rx_busy(1'b0), .i_irq_mask(mask), .i_tk(tk), .o_tk(o_tk), .o_tk_oe(o_tk_oe),
		.i_rk(rk), .o_rk(o_rk), .o_rk_oe(o_rk_oe), .i_tf(tf), .o_td(td), .o_tx_int_clk(tclk),
		.o_rx_int_clk(rclk), .o_div_active(dact), .o_tx_start(tstart),
		.o_tx_holding_free(tfree), .o_tx_all_empty(tempty), .o_flag_status(flags), .o_irq(irq));
	codec_model codec_model_i (.i_sys_clk(i_sys_clk), .i_en(pen), .o_tk(ptk), .o_tf(tf));
	// verdict and end of run
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tick;
		@(posedge i_sys_clk);
		#1;
	endtask
	// counted comparison, reported at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic [31:0] got, input logic [31:0] exp);
		check(got, exp);
	endtask
	task automatic cmp_bit(input logic [31:0] got, input logic [31:0] exp);
		check(got, exp);
	endtask
	task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
		check(got, exp);
	endtask
	// a wait that ran out ends the run
	task automatic bound(input integer i, input integer lim);
		if (i >= lim)
		begin
			errors = errors + 1;
			results;
		end
	endtask
	// length of one whole level of the internal clock, after two changes
	task automatic level(output integer c);
		integer n;
		logic p;
		c = 0;
		n = 0;
		while (n < 3 && c < 9000)
		begin
			p = tclk;
			tick;
			c = c + 1;
			if (tclk !== p)
			begin
				n = n + 1;
				if (n < 3)
					c = 0;
			end
		end
		bound(c, 9000);
	endtask
	// queue the expected bits, then strobe one random word in
	task automatic put;
		integer b;
		logic [31:0] d;
		d = $random(seed);
		for (b = 0; b <= dlen; b = b + 1)
			q.push_back(d[msbf ? dlen - b : b]);
		wdata = d;
		wr = 1'b1;
		tick;
		wr = 1'b0;
	endtask
	// two words, the second queued while the first shifts
	task automatic xfer;
		integer i;
		put;
		for (i = 0; i < 400 && tstart !== 1'b1; i = i + 1)
			tick;
		bound(i, 400);
		put;
		tick;
		cmp_flag({tempty, tfree, o_tk_oe}, {2'h0, tout == CKO_TRANSFER});
		for (i = 0; i < 4000 && tempty !== 1'b1; i = i + 1)
			tick;
		bound(i, 4000);
		cmp_flag({tempty, tfree, flags, td, irq}, {4'hf, ddef, |mask});
		cmp_flag({o_rk_oe, o_rk ^ rclk}, {rout == CKO_CONTINUOUS, rinv});
		cmp_cnt(q.size(), 0);
	endtask
	// serial line sampled on each rising internal clock once a frame began
	always @(posedge i_sys_clk)
	begin
		#1;
		if (tstart === 1'b1)
			arm = 1'b1;
		if (arm && tp === 1'b0 && tclk === 1'b1 && q.size() > 0)
			cmp_bit(td, q.pop_front());
		if (q.size() == 0)
			arm = 1'b0;
		tp = tclk;
	end
	initial
	begin
		integer i, c;
		integer vals[4];
		vals = '{1, 2, 5, 4095};
		repeat (4) tick;
		i_rst = 1'b0;
		tick;
		cmp_flag({tempty, tfree, flags}, 4'hf);
		for (i = 0; i < 4; i = i + 1)
		begin
			div = 12'(vals[i]);
			level(c);
			cmp_cnt(c, vals[i]);
		end
		div = 12'h000;
		repeat (4) tick;
		cmp_flag({dact, tclk, rclk}, 3'h1);
		div = 12'h003;
		tout = CKO_TRANSFER;
		dlen = 5'(3 + {$random(seed)} % 13);
		msbf = 1'($random(seed));
		ddef = 1'($random(seed));
		mask = 2'($random(seed));
		xfer;
		tsrc = CK_SRC_PIN; // partner supplies the clock, pin stays an input
		tout = CKO_INPUT;
		rout = CKO_TRANSFER; // receive source stays the divider
		pen = 1'b1;
		xfer;
		pen = 1'b0;
		results;
	end
endmodule
`default_nettype wire
